// >>> logic/ccr_pkg.sv
package ccr_pkg;
    // Register map
    localparam logic [3:0] CCR_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CCR_ADDR_STAT = 4'h1;
    localparam int CCR_AW = 4;

    // Control/status field positions
    localparam int CCR_BIT_ENABLE = 7;
    localparam int CCR_BIT_RESULT = 6;
    localparam int CCR_BIT_INVERT = 4;
    localparam int CCR_BIT_SPEED = 2;
    localparam int CCR_BIT_HYST = 1;
    localparam int CCR_BIT_SYNC = 0;

    // Reset values
    localparam logic CCR_RST_ENABLE = 1'h0;
    localparam logic CCR_RST_INVERT = 1'h0;
    localparam logic CCR_RST_SPEED = 1'h1;
    localparam logic CCR_RST_HYST = 1'h0;
    localparam logic CCR_RST_SYNC = 1'h0;
    localparam logic [7:0] CCR_RST_RDATA = 8'h00;

    // Writable settings
    typedef struct packed {
        logic comparator_enable;
        logic output_invert;
        logic speed_power_select;
        logic hysteresis_enable;
        logic timer_sync_enable;
    } ccr_ctrl_t;

    // Controls sent to the analog core
    typedef struct packed {
        logic enable;
        logic inputs_enable;
        logic hysteresis;
        logic speed_power;
    } ccr_analog_t;
endpackage

// >>> logic/ccr_sync_latch.sv
`timescale 1ns/1ps
module ccr_sync_latch
    import ccr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic timer_clk_i,
    input wire logic sync_en_i,
    input wire logic data_i,
    output logic data_o
);
    logic t1_prev;
    logic held;

    // Timer clock sampled as a level; falling edge found from prior sample
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            t1_prev <= 1'h0;
        end else if (ce_i) begin
            t1_prev <= timer_clk_i;
        end
    end

    // Capture on each timer falling edge
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            held <= 1'h0;
        end else if (ce_i && t1_prev && !timer_clk_i) begin
            held <= data_i;
        end
    end

    // Select latched or direct path
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 1'h0;
        end else if (ce_i) begin
            data_o <= sync_en_i ? held : data_i;
        end
    end
endmodule

// >>> logic/ccr_top.sv
`timescale 1ns/1ps
// Contract
// - Output invert is a read/write bit at position 4, cleared by reset.
// - With invert set the raw result is inverted before any consumer, else it passes.
// - Read-only bit 6 reports the processed result, high when positive input is above with invert clear.
// - Hysteresis enable at bit 1 resets to zero and drives the analog hysteresis control.
// - The enable bit switches the comparator on; clearing it also disables all inputs.
// - With sync set the result is latched on each timer clock falling edge, else unlatched.
module ccr_top
    import ccr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [CCR_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic raw_compare_i,
    input wire logic timer_clk_i,
    output logic enable_o,
    output logic inputs_enable_o,
    output logic hysteresis_o,
    output logic speed_power_o,
    output logic result_o
);
    ccr_ctrl_t ctrl;
    ccr_analog_t analog;
    logic polarized;
    logic processed;
    logic processed_q;

    function automatic logic [7:0] ccr_pack(input ccr_ctrl_t c, input logic res);
        logic [7:0] v;
        v = 8'h00;
        v[CCR_BIT_ENABLE] = c.comparator_enable;
        v[CCR_BIT_RESULT] = res;
        v[CCR_BIT_INVERT] = c.output_invert;
        v[CCR_BIT_SPEED] = c.speed_power_select;
        v[CCR_BIT_HYST] = c.hysteresis_enable;
        v[CCR_BIT_SYNC] = c.timer_sync_enable;
        return v;
    endfunction

    // Settings register; bits 6, 5, 3 are not stored so writes to them vanish
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl.comparator_enable <= CCR_RST_ENABLE;
            ctrl.output_invert <= CCR_RST_INVERT;
            ctrl.speed_power_select <= CCR_RST_SPEED;
            ctrl.hysteresis_enable <= CCR_RST_HYST;
            ctrl.timer_sync_enable <= CCR_RST_SYNC;
        end else if (ce_i && wr_i && addr_i == CCR_ADDR_CTRL) begin
            ctrl.comparator_enable <= wdata_i[CCR_BIT_ENABLE];
            ctrl.output_invert <= wdata_i[CCR_BIT_INVERT];
            ctrl.speed_power_select <= wdata_i[CCR_BIT_SPEED];
            ctrl.hysteresis_enable <= wdata_i[CCR_BIT_HYST];
            ctrl.timer_sync_enable <= wdata_i[CCR_BIT_SYNC];
        end
    end

    // Polarity applied ahead of every consumer
    assign polarized = raw_compare_i ^ ctrl.output_invert;

    ccr_sync_latch u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .timer_clk_i(timer_clk_i),
        .sync_en_i(ctrl.timer_sync_enable),
        .data_i(polarized),
        .data_o(processed)
    );

    // Analog controls; inputs follow enable so a disabled core draws nothing
    always_comb begin
        analog.enable = ctrl.comparator_enable;
        analog.inputs_enable = ctrl.comparator_enable;
        analog.hysteresis = ctrl.hysteresis_enable;
        analog.speed_power = ctrl.speed_power_select;
    end

    // Registered outputs toward analog core and consumers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            enable_o <= CCR_RST_ENABLE;
            inputs_enable_o <= CCR_RST_ENABLE;
            hysteresis_o <= CCR_RST_HYST;
            speed_power_o <= CCR_RST_SPEED;
            processed_q <= 1'h0;
        end else if (ce_i) begin
            enable_o <= analog.enable;
            inputs_enable_o <= analog.inputs_enable;
            hysteresis_o <= analog.hysteresis;
            speed_power_o <= analog.speed_power;
            processed_q <= processed;
        end
    end

    assign result_o = processed_q;

    // Read port; status alias gives result alone, unmapped reads zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= CCR_RST_RDATA;
        end else if (ce_i) begin
            if (rd_i && addr_i == CCR_ADDR_CTRL) begin
                rdata_o <= ccr_pack(ctrl, processed);
            end else if (rd_i && addr_i == CCR_ADDR_STAT) begin
                rdata_o <= {7'h00, processed};
            end else begin
                rdata_o <= CCR_RST_RDATA;
            end
        end
    end
endmodule

// >>> bench/ccr_analog.sv
`timescale 1ns/1ps
module ccr_analog (
    input wire logic clk_sys_i,
    input wire logic enable_i,
    input wire logic vp_above_i,
    output logic raw_compare_o,
    output logic timer_clk_o
);
    logic [1:0] div = 2'h0;
    // A switched-off core reports low, never a stale trip
    assign raw_compare_o = enable_i & vp_above_i;
    // Free-running slow timer source, one third of the system rate
    always @(posedge clk_sys_i) div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    assign timer_clk_o = div[1];
endmodule

// >>> bench/ccr_chk_sva.sv
`timescale 1ns/1ps
module ccr_chk
    import ccr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [CCR_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic raw_compare_i,
    input wire logic timer_clk_i,
    input wire logic enable_o,
    input wire logic inputs_enable_o,
    input wire logic hysteresis_o,
    input wire logic speed_power_o,
    input wire logic result_o
);
    logic [7:0] ctl, ctl_d;
    logic p1, p2, s1, s2, tq;
    default clocking @(posedge clk_sys_i); endclocking
    // A frozen cycle aborts open attempts rather than stretching their delays
    default disable iff (rst_i || !ce_i);
    // Shadow register and two-stage result path; reset matches the design's
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            {ctl, ctl_d, p1, p2, s1, s2, tq} <= {8'h04, 8'h04, 5'h00};
        end else if (ce_i) begin
            ctl <= (wr_i && addr_i == CCR_ADDR_CTRL) ? (wdata_i & 8'h97) : ctl;
            {ctl_d, p1, p2, s1, s2, tq} <= {ctl, raw_compare_i ^ ctl[4], p1, ctl[0], s1, timer_clk_i};
        end
    end
    sequence s_ctrl_wr;
        wr_i && addr_i == CCR_ADDR_CTRL;
    endsequence
    sequence s_fall;
        ctl[0] && tq && !timer_clk_i;
    endsequence
    sequence s_quiet;
        ctl[0] && !(tq && !timer_clk_i);
    endsequence
    AST_READBACK: assert property (rd_i && addr_i == CCR_ADDR_CTRL |=> (rdata_o & 8'hBF) == ctl_d)
        else $error("readback");
    AST_HYST: assert property (s_ctrl_wr |=> ##1 hysteresis_o == ctl_d[1])
        else $error("hysteresis");
    AST_ENABLE: assert property (s_ctrl_wr |=> ##1 {enable_o, inputs_enable_o} == {2{ctl_d[7]}})
        else $error("enable");
    AST_SPEED: assert property (s_ctrl_wr |=> ##1 speed_power_o == ctl_d[2])
        else $error("speed");
    AST_RESULT: assert property (!s2 |-> result_o == p2)
        else $error("result");
    AST_STATUS: assert property (rd_i && addr_i == CCR_ADDR_CTRL |=> s2 || rdata_o[6] == p2)
        else $error("status bit");
    // Capture lands in the latch, then two flops reach the pin
    AST_SYNC_CAP: assert property (s_fall ##1 ctl[0] |=> ##1 result_o == $past(p2))
        else $error("sync capture");
    AST_SYNC_HOLD: assert property (s_quiet ##1 ctl[0] |=> ##1 $stable(result_o))
        else $error("sync hold");
    AST_STAT_ALIAS: assert property (rd_i && addr_i == CCR_ADDR_STAT |=> s2 || rdata_o == {7'h00, p2})
        else $error("status alias");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("idle read data");
endmodule
bind ccr_top ccr_chk u_chk (.*);

// >>> bench/tb_comparator_control_register.sv
`timescale 1ns/1ps
module tb_comparator_control_register import ccr_pkg::*;;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic vp = 1'b0, rd_q = 1'b0;
    logic raw, tclk, enable_o, inputs_enable_o, hysteresis_o, speed_power_o, result_o;
    logic [CCR_AW-1:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, lfsr = 8'h35, w, x, e, exp_q[$];
    int errors = 0, checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    ccr_analog u_ccr_analog (.clk_sys_i, .enable_i(enable_o), .vp_above_i(vp),
        .raw_compare_o(raw), .timer_clk_o(tclk));
    ccr_top u_ccr_top (.raw_compare_i(raw), .timer_clk_i(tclk), .*);
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // One bus cycle plus an idle edge, so no strobe is driven twice in a step
    task automatic bus(input logic wn, input logic [3:0] a, input logic [7:0] d);
        if (!wn) exp_q.push_back(d);
        {wr_i, rd_i, addr_i, wdata_i} <= {wn, !wn, a, d};
        @(posedge clk_sys_i) {wr_i, rd_i} <= 2'h0;
        @(posedge clk_sys_i);
    endtask
    task automatic end_of_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys_i) begin
        rd_q <= rd_i;
        if (rd_q) begin
            e = exp_q.pop_front();
            checked++;
            if (rdata_o !== e) begin
                errors++;
                $display("Error %0t got %h exp %h", $time, rdata_o, e);
            end
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, CCR_ADDR_CTRL, 8'h04);
        bus(1'b0, 4'h2, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 24; i++) begin
            lfsr = nxt(nxt(lfsr));
            // Speed bit kept set: clearing it is a reserved setting
            w = (lfsr & 8'hFE) | 8'h04;
            vp <= lfsr[3] ^ lfsr[6];
            bus(1'b1, CCR_ADDR_CTRL, w);
            bus(1'b1, 4'h1, ~w);
            x = {w[7], (w[7] & vp) ^ w[4], 1'b0, w[4], 1'b0, w[2:1], 1'b0};
            bus(1'b0, CCR_ADDR_CTRL, x);
            bus(1'b0, CCR_ADDR_STAT, {7'h00, x[6]});
        end
        $display("register test done");
        bus(1'b1, CCR_ADDR_CTRL, 8'h95);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys_i) vp <= lfsr[i % 8];
        end
        $display("sync test done");
        // Core off, invert on; a write while frozen must not land
        bus(1'b1, CCR_ADDR_CTRL, 8'h14);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        bus(1'b1, CCR_ADDR_CTRL, 8'h80);
        ce_i <= 1'b1;
        bus(1'b0, CCR_ADDR_CTRL, 8'h54);
        $display("freeze test done");
        repeat (2) @(posedge clk_sys_i);
        end_of_test();
    end
endmodule
